/* src/spi_reg_cfg.svh */
// constants for the serial register access slave
`ifndef SPI_REG_CFG_SVH
`define SPI_REG_CFG_SVH
`define ADDR_W 7
`define BYTE_W 8
`define BIT_CNT_W 3
`define BIT_LAST 3'h7
`define BIT_STEP 3'h1
`define SCK_IDLE 1'b0
`define SEL_IDLE 1'b1
`define MOSI_IDLE 1'b0
`define DIR_BIT 0
`define ADDR_HI 7
`define ADDR_LO 1
`define DIR_READ 1'h1
`define FIFO_ADDR_DEFAULT 7'h05
`define ADDR_STEP 7'h01
`endif

/* src/spi_reg_pkg.sv */
// types for the serial register access slave
package spi_reg_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_cmd = 3'b010,
    st_data = 3'b100
  } xfer_e;
endpackage

/* src/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`include "spi_reg_cfg.svh"
module pin_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // pin side
  input wire logic pin,
  input wire logic rst_val,
  // core side
  output logic level
);
  logic s1; // first stage, read only by s2
  logic s2;
  logic s3;
  // shift chain; the level follows only when stages two and three agree
  // stages reset to the idle level too, so no false change follows reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1 <= rst_val;
      s2 <= rst_val;
      s3 <= rst_val;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // filtered level; rst_val is a constant tie at the instance
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      level <= rst_val;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule // pin_sync

/* src/spi_register_access_slave.sv */
// serial host port slave giving register read and write access
`timescale 1ns/1ns
`include "spi_reg_cfg.svh"
module spi_register_access_slave (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // serial pins
  input wire logic sck,
  input wire logic select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // register side write port
  output logic wr_en,
  output logic [`ADDR_W-1:0] wr_addr,
  output logic [`BYTE_W-1:0] wr_data,
  // register side read port
  output logic rd_en,
  output logic [`ADDR_W-1:0] rd_addr,
  input wire logic [`BYTE_W-1:0] rd_data,
  // fifo address, tie to a constant
  input wire logic [`ADDR_W-1:0] fifo_addr
);
  // filtered pin levels
  logic sck_lv;
  logic sel_lv;
  logic mosi_lv;
  logic sck_d; // previous filtered clock for edge finding
  logic rise;
  logic fall;
  spi_reg_pkg::xfer_e state;
  logic [`BIT_CNT_W-1:0] bit_cnt; // bits received in current byte
  logic [`BYTE_W-1:0] shift_in;
  logic [`BYTE_W-1:0] shift_out;
  logic [`ADDR_W-1:0] addr;
  logic is_read;
  logic byte_done;
  logic [`BYTE_W-1:0] next_byte;

  // address step that honours the fifo exception
  function automatic logic [`ADDR_W-1:0] step_addr(input logic [`ADDR_W-1:0] a,
                                                  input logic [`ADDR_W-1:0] f);
    step_addr = (a == f) ? a : a + `ADDR_STEP;
  endfunction

  pin_sync u_sck (.core_clk(core_clk), .rstn(rstn), .pin(sck), .rst_val(`SCK_IDLE),
                  .level(sck_lv));
  pin_sync u_sel (.core_clk(core_clk), .rstn(rstn), .pin(select_n), .rst_val(`SEL_IDLE),
                  .level(sel_lv));
  pin_sync u_mosi (.core_clk(core_clk), .rstn(rstn), .pin(mosi), .rst_val(`MOSI_IDLE),
                   .level(mosi_lv));

  // edge finder on the filtered clock; clock idles low
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sck_d <= `SCK_IDLE;
    end else begin
      sck_d <= sck_lv;
    end
  end
  assign rise = sck_lv && !sck_d && !sel_lv;
  assign fall = !sck_lv && sck_d && !sel_lv;
  assign byte_done = rise && (bit_cnt == `BIT_LAST);
  assign next_byte = {shift_in[`BYTE_W-2:0], mosi_lv};

  // bit counter and input shifter; select high drops any partial byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bit_cnt <= '0;
      shift_in <= '0;
    end else if (sel_lv) begin
      bit_cnt <= '0;
      shift_in <= '0;
    end else if (rise) begin
      bit_cnt <= bit_cnt + `BIT_STEP;
      shift_in <= next_byte;
    end
  end

  // transaction sequencer: first byte is command, later bytes are data
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= spi_reg_pkg::st_idle;
      addr <= '0;
      is_read <= 1'b0;
    end else begin
      case (state)
        spi_reg_pkg::st_idle: begin
          if (!sel_lv) begin
            state <= spi_reg_pkg::st_cmd;
          end
        end
        spi_reg_pkg::st_cmd: begin
          if (sel_lv) begin
            state <= spi_reg_pkg::st_idle;
          end else if (byte_done) begin
            is_read <= (next_byte[`DIR_BIT] == `DIR_READ);
            addr <= next_byte[`ADDR_HI:`ADDR_LO];
            state <= spi_reg_pkg::st_data;
          end
        end
        spi_reg_pkg::st_data: begin
          if (sel_lv) begin
            state <= spi_reg_pkg::st_idle;
          end else if (byte_done) begin
            if (is_read) begin
              addr <= next_byte[`ADDR_HI:`ADDR_LO];
            end else begin
              addr <= step_addr(addr, fifo_addr);
            end
          end
        end
        default: begin
          state <= spi_reg_pkg::st_idle;
        end
      endcase
    end
  end

  // register write strobe, one cycle per completed write data byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      wr_en <= (state == spi_reg_pkg::st_data) && !is_read && byte_done && !sel_lv;
      if ((state == spi_reg_pkg::st_data) && !is_read && byte_done) begin
        wr_addr <= addr;
        wr_data <= next_byte;
      end
    end
  end

  // read strobe when any read-address byte completes
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_en <= 1'b0;
      rd_addr <= '0;
    end else begin
      rd_en <= byte_done && !sel_lv && (next_byte[`DIR_BIT] == `DIR_READ)
               && ((state == spi_reg_pkg::st_cmd)
                   || ((state == spi_reg_pkg::st_data) && is_read));
      if (byte_done) begin
        rd_addr <= next_byte[`ADDR_HI:`ADDR_LO]; // holds until the next byte
      end
    end
  end

  // output shifter: load read data after strobe, shift on falling edges
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      shift_out <= '0;
      miso <= 1'b0;
    end else if (sel_lv) begin
      shift_out <= '0;
      miso <= 1'b0;
    end else begin
      if (rd_en) begin
        shift_out <= rd_data; // register answers in the strobe cycle
      end else if (fall) begin
        miso <= shift_out[`BYTE_W-1];
        shift_out <= {shift_out[`BYTE_W-2:0], 1'b0};
      end
    end
  end
  // drive only while selected
  assign miso_oe = !sel_lv;

  // checks; each label line carries the rule it guards
  sequence cmd_byte_s;
    (state == spi_reg_pkg::st_cmd) && byte_done && !next_byte[`DIR_BIT];
  endsequence
  // a write data byte completing while selected
  sequence wr_byte_s;
    (state == spi_reg_pkg::st_data) && !is_read && byte_done;
  endsequence
  fifo_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == spi_reg_pkg::st_data) && !is_read && byte_done && (addr == fifo_addr)
    |=> addr == $past(addr)) else $error("fifo address moved");
  incr_addr_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (state == spi_reg_pkg::st_data) && !is_read && byte_done && !sel_lv
    && (addr != fifo_addr) |=> addr == $past(addr) + `ADDR_STEP)
    else $error("burst address not incremented");
  write_dir_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cmd_byte_s |=> !is_read) else $error("write flag misdecoded");
  cmd_addr_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cmd_byte_s |=> addr == $past(next_byte[`ADDR_HI:`ADDR_LO]))
    else $error("address field misdecoded");
  wr_strobe_a: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_en |-> $past(state == spi_reg_pkg::st_data) && !$past(is_read))
    else $error("write outside data phase");
  wr_data_a: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_byte_s |=> wr_en && (wr_data == $past(next_byte)) && (wr_addr == $past(addr)))
    else $error("data byte not written");
  drop_part_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sel_lv |=> bit_cnt == '0 && state == spi_reg_pkg::st_idle)
    else $error("partial byte kept");
  abort_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sel_lv |=> !wr_en && !rd_en) else $error("strobe after deselect");
  msb_first_a: assert property (@(posedge core_clk) disable iff (!rstn)
    rise |=> shift_in[0] == $past(mosi_lv)) else $error("shift order wrong");
  miso_fall_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !fall && !sel_lv && !$past(sel_lv) |=> $stable(miso))
    else $error("miso changed off falling edge");
  // a deselect in the load cycle clears the shifter instead of loading it
  rd_next_a: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_en && !sel_lv |=> shift_out == $past(rd_data)) else $error("read data not loaded");
  rd_cause_a: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_en |-> $past(byte_done) && ($past(next_byte[`DIR_BIT]) == `DIR_READ)
    && (rd_addr == $past(next_byte[`ADDR_HI:`ADDR_LO])))
    else $error("read strobe without read address byte");
endmodule // spi_register_access_slave

/* verif/spi_host_model.sv */
// host side serial master model driving select, clock and data pins
`timescale 1ns/1ns
module spi_host_model (
  // clock
  input wire logic core_clk,
  // serial pins
  output logic sck,
  output logic select_n,
  output logic mosi,
  input wire logic miso
);
  // pins idle: clock low, device not selected
  initial begin
    sck = 1'b0;
    select_n = 1'b1;
    mosi = 1'b0;
  end
  // wait a number of core cycles
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // select stays low over one transaction and high between two
  task automatic sel(input logic lvl);
    tick(4);
    select_n <= lvl;
    // a released data line must not keep showing the last bit
    if (lvl) mosi <= ~mosi;
    tick(12);
  endtask
  // n bits msb first; data changes with the fall
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      mosi <= tx[i];
      tick(4);
      sck <= 1'b1;
      // sample late in the high phase, well clear of the output update
      tick(3);
      rx[i] = miso;
      tick(1);
      sck <= 1'b0;
    end
  endtask
endmodule // spi_host_model

/* verif/tb_top.sv */
// self-checking bench for the serial register access slave
`timescale 1ns/1ns
`include "spi_reg_cfg.svh"
module tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic sck, select_n, mosi, miso, miso_oe, wr_en, rd_en;
  logic [`ADDR_W-1:0] wr_addr, rd_addr;
  logic [`ADDR_W-1:0] fifo_cur = `FIFO_ADDR_DEFAULT; // fifo address seen by the block
  logic [`BYTE_W-1:0] wr_data, rd_data, rx;
  logic [14:0] wq[$]; // captured writes as address and data
  logic [6:0] rq[$]; // captured read addresses
  logic [7:0] dat[3] = '{8'h3c, 8'hc3, 8'h81}; // burst payload
  int err_total = 0;
  int compares = 0;
  always #5 core_clk = ~core_clk;
  // register stand-in: read value derived from the address, combinational
  assign rd_data = {rd_addr, 1'b1} ^ 8'h3c;
  spi_register_access_slave u_spi_register_access_slave (
    .core_clk(core_clk), .rstn(rstn), .sck(sck), .select_n(select_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .fifo_addr(fifo_cur));
  spi_host_model u_spi_host_model (
    .core_clk(core_clk), .sck(sck), .select_n(select_n), .mosi(mosi), .miso(miso));
  // strobes are collected on the falling edge where they are settled
  always @(negedge core_clk) begin
    if (wr_en === 1'b1) wq.push_back({wr_addr, wr_data});
    if (rd_en === 1'b1) rq.push_back(rd_addr);
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] b);
    u_spi_host_model.xfer(b, 8, rx);
  endtask
  // one write command followed by three data bytes
  task automatic burst(input logic [6:0] a);
    wq.delete();
    rq.delete();
    u_spi_host_model.sel(1'b0);
    send({a, 1'b0});
    foreach (dat[i]) send(dat[i]);
    u_spi_host_model.sel(1'b1);
    chk("write count", 16'(wq.size()), 16'h0003);
    chk("no read strobe", 16'(rq.size()), 16'h0000);
  endtask
  task automatic t_incr();
    burst(7'h0a);
    foreach (dat[i]) chk("incr write", {1'b0, wq[i]}, {1'b0, 7'h0a + 7'(i), dat[i]});
    $display("test incr done");
  endtask
  task automatic t_fifo();
    burst(`FIFO_ADDR_DEFAULT);
    foreach (dat[i]) chk("fifo write", {1'b0, wq[i]}, {1'b0, `FIFO_ADDR_DEFAULT, dat[i]});
    // moved fifo address: the burst climbs onto it, then stays there
    fifo_cur <= 7'h0b;
    burst(7'h0a);
    chk("fifo climb", {1'b0, wq[0]}, {1'b0, 7'h0a, dat[0]});
    chk("fifo reach", {1'b0, wq[1]}, {1'b0, 7'h0b, dat[1]});
    chk("fifo stay", {1'b0, wq[2]}, {1'b0, 7'h0b, dat[2]});
    fifo_cur <= `FIFO_ADDR_DEFAULT;
    $display("test fifo done");
  endtask
  // two read addresses then the trailer; data lags one byte
  task automatic t_read();
    logic [7:0] got[3];
    rq.delete();
    u_spi_host_model.sel(1'b0);
    u_spi_host_model.xfer({7'h10, 1'b1}, 8, got[0]);
    u_spi_host_model.xfer({7'h11, 1'b1}, 8, got[1]);
    u_spi_host_model.xfer(8'h00, 8, got[2]);
    chk("oe on", {15'h0000, miso_oe}, 16'h0001);
    u_spi_host_model.sel(1'b1);
    chk("oe off", {15'h0000, miso_oe}, 16'h0000);
    chk("read count", 16'(rq.size()), 16'h0002);
    chk("read addr", {9'h000, rq[1]}, 16'h0011);
    chk("read data 0", {8'h00, got[1]}, 16'h001d);
    chk("read data 1", {8'h00, got[2]}, 16'h001f);
    $display("test read done");
  endtask
  // data byte cut short, then a fresh transaction
  task automatic t_abort();
    wq.delete();
    u_spi_host_model.sel(1'b0);
    send({7'h30, 1'b0});
    u_spi_host_model.xfer(8'hff, 4, rx);
    u_spi_host_model.sel(1'b1);
    u_spi_host_model.sel(1'b0);
    send({7'h20, 1'b0});
    send(8'h5a);
    u_spi_host_model.sel(1'b1);
    chk("abort count", 16'(wq.size()), 16'h0001);
    chk("fresh write", {1'b0, wq[0]}, {1'b0, 7'h20, 8'h5a});
    $display("test abort done");
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_incr();
    t_fifo();
    t_read();
    t_abort();
    close_out();
  end
endmodule // tb_top
